// ===== logic/disk_read_sector_sequencer.sv
// Functional notes
// - id mark search never times out
// - checksum select clear means id checksum
// - read error with retry restarts id search
// - marker byte mismatch with retry retries id
// - compared id bytes also stored to id read
// - flag byte stored but never compared
// - checksum field takes count plus one, check mode
// - id errors latched until retry instruction checks
// - data mark search bounded by count field
// - fail bit halts on sync error, flag set
// - data marker must equal immediate value
// - buffer instructions move count plus one bytes
// - no_transfer_source checks only; compare mode compares buffer
// - last marker ends the data field
// - ecc field checked over count plus one bytes
// - no read gate bit drops read gate
// - jump to loop only while sectors remain
// - fail bit at sector end halts on ecc
// - stop code ends the command at once
module byte_fifo #(
   parameter int W = 9,
   parameter int D = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int PW = $clog2(D);
   logic [D-1:0][W-1:0] mem_reg;
   logic [PW-1:0] wr_reg;
   logic [PW-1:0] rd_reg;
   logic [PW:0] cnt_reg;
   logic push;
   logic pop;
   assign in_ready_o = (cnt_reg != (PW+1)'(D));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_reg <= '0;
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_reg[wr_reg] <= in_data_i;
            wr_reg <= (wr_reg == PW'(D-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_reg <= (rd_reg == PW'(D-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : byte_fifo

module disk_read_sector_sequencer (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic ABORT_I,
   input wire logic STORE_WR_I,
   input wire logic [disk_seq_pkg::ADDR_W-1:0] STORE_ADDR_I,
   input wire disk_seq_pkg::instr_s STORE_DATA_I,
   input wire logic [disk_seq_pkg::ADDR_W-1:0] START_ADDR_I,
   input wire logic [disk_seq_pkg::ADDR_W-1:0] LOOP_ADDR_I,
   input wire logic SECTOR_COUNT_WR_I,
   input wire logic [7:0] SECTOR_COUNT_I,
   input wire logic READ_COMPARE_BIT_I,
   input wire logic [23:0] TARGET_ID_I,
   input wire logic [7:0] DISK_BYTE_I,
   input wire logic DISK_VALID_I,
   input wire logic MARK_DETECTED_I,
   input wire logic [7:0] CMP_DATA_I,
   output logic CMP_TAKE_O,
   output disk_seq_pkg::xfer_s XFER_O,
   output logic XFER_VALID_O,
   input wire logic XFER_READY_I,
   output logic READ_GATE_O,
   output logic BUSY_O,
   output logic SEQUENCER_STOPPED_O,
   output disk_seq_pkg::status_s STATUS_O,
   output logic [31:0] ID_READ_O,
   output logic [7:0] SECTOR_COUNT_O
);
   disk_seq_pkg::instr_s store_reg [disk_seq_pkg::STORE_DEPTH];
   disk_seq_pkg::instr_s ins;
   disk_seq_pkg::seq_state_e state_reg, state_next;
   disk_seq_pkg::status_s st_reg, st_next;
   logic [disk_seq_pkg::ADDR_W-1:0] pc_reg, pc_next;
   logic [7:0] cnt_reg, cnt_next, sc_reg, sc_next, sc_after;
   logic [15:0] crc_reg, crc_next;
   logic [1:0] idx_reg, idx_next;
   logic [3:0][7:0] id_reg, id_next;
   logic [3:0][7:0] target;
   logic gate_reg, gate_next, stop_reg, stop_next;
   logic mism_reg, mism_next, idcrc_reg, idcrc_next, derr_reg, derr_next;
   logic push, take, err, done, ovr, hit, fin, retry_go, sync_halt, ecc_halt;
   logic fifo_ready;
   disk_seq_pkg::xfer_s push_data;

   assign ins = store_reg[pc_reg];
   assign hit = (DISK_BYTE_I == ins.value);
   assign target = {8'h00, TARGET_ID_I};
   assign push_data = '{data: DISK_BYTE_I, last: ins.last_bit && (cnt_reg == 8'h00)};

   byte_fifo #(.W($bits(disk_seq_pkg::xfer_s)), .D(disk_seq_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(CLK_SYS_I),
      .rst_i(RESET_I),
      .in_data_i(push_data),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .out_data_o(XFER_O),
      .out_valid_o(XFER_VALID_O),
      .out_ready_i(XFER_READY_I)
   );

   always_ff @(posedge CLK_SYS_I)
   begin
      if (STORE_WR_I && state_reg == disk_seq_pkg::ST_IDLE)
      begin
         store_reg[STORE_ADDR_I] <= STORE_DATA_I;
      end
   end

   always_comb
   begin
      state_next = state_reg;
      pc_next = pc_reg;
      cnt_next = cnt_reg;
      sc_next = sc_reg;
      crc_next = crc_reg;
      idx_next = idx_reg;
      id_next = id_reg;
      st_next = st_reg;
      gate_next = gate_reg;
      mism_next = mism_reg;
      idcrc_next = idcrc_reg;
      derr_next = derr_reg;
      stop_next = 1'b0;
      push = 1'b0;
      take = 1'b0;
      err = 1'b0;
      done = 1'b0;
      ovr = 1'b0;
      fin = 1'b0;
      retry_go = 1'b0;
      sync_halt = 1'b0;
      ecc_halt = 1'b0;
      sc_after = sc_reg;
      unique case (state_reg)
         disk_seq_pkg::ST_IDLE:
         begin
            if (SECTOR_COUNT_WR_I)
            begin
               sc_next = SECTOR_COUNT_I;
               pc_next = START_ADDR_I;
               st_next = '0;
               mism_next = 1'b0;
               idcrc_next = 1'b0;
               derr_next = 1'b0;
               state_next = disk_seq_pkg::ST_FETCH;
            end
         end
         disk_seq_pkg::ST_FETCH:
         begin
            if (ins.opt == disk_seq_pkg::OPT_STOP)
            begin
               state_next = disk_seq_pkg::ST_IDLE;
               gate_next = 1'b0;
               stop_next = 1'b1;
            end
            else
            begin
               cnt_next = ins.count;
               gate_next = ins.read_gate;
               state_next = disk_seq_pkg::ST_RUN;
            end
         end
         disk_seq_pkg::ST_RUN:
         begin
            if (DISK_VALID_I)
            begin
               unique case (ins.opt)
                  disk_seq_pkg::OPT_ID_MARK:
                  begin
                     if (MARK_DETECTED_I)
                     begin
                        done = hit;
                        err = !hit && ins.retry_bit;
                     end
                  end
                  disk_seq_pkg::OPT_DATA_MARK:
                  begin
                     if (MARK_DETECTED_I && hit)
                     begin
                        done = 1'b1;
                     end
                     else if (cnt_reg == 8'h00)
                     begin
                        err = 1'b1;
                     end
                     else
                     begin
                        cnt_next = cnt_reg - 8'h01;
                     end
                  end
                  default:
                  begin
                     crc_next = disk_seq_pkg::crc_byte(crc_reg, DISK_BYTE_I);
                     unique case (ins.src)
                        disk_seq_pkg::SRC_IMM: err = ins.compare_bit && !hit;
                        disk_seq_pkg::SRC_ID:
                        begin
                           id_next[idx_reg] = DISK_BYTE_I;
                           if (ins.compare_bit && idx_reg != disk_seq_pkg::ID_FLAG_IDX
                               && DISK_BYTE_I != target[idx_reg])
                           begin
                              mism_next = 1'b1;
                           end
                           idx_next = idx_reg + 2'h1;
                        end
                        disk_seq_pkg::SRC_BUF:
                        begin
                           if (ins.compare_bit && READ_COMPARE_BIT_I)
                           begin
                              take = 1'b1;
                              derr_next = derr_reg || (CMP_DATA_I != DISK_BYTE_I);
                           end
                           else
                           begin
                              push = 1'b1;
                              ovr = !fifo_ready;
                           end
                        end
                        disk_seq_pkg::SRC_NO_TRANSFER_SOURCE: ;
                        default: ;
                        disk_seq_pkg::SRC_CHECK:
                        begin
                           if (cnt_reg == 8'h00 && crc_next != 16'h0000)
                           begin
                              if (ins.checksum_select)
                              begin
                                 derr_next = 1'b1;
                              end
                              else
                              begin
                                 idcrc_next = 1'b1;
                              end
                           end
                        end
                     endcase
                     done = (cnt_reg == 8'h00);
                     cnt_next = cnt_reg - 8'h01;
                  end
               endcase
               if (done && ins.opt != disk_seq_pkg::OPT_NORMAL)
               begin
                  crc_next = disk_seq_pkg::crc_byte(disk_seq_pkg::CRC_INIT, DISK_BYTE_I);
                  idx_next = 2'h0;
               end
               if (ovr)
               begin
                  st_next.overrun_flag = 1'b1;
                  stop_next = 1'b1;
                  gate_next = 1'b0;
                  state_next = disk_seq_pkg::ST_IDLE;
               end
               else if (err && ins.retry_bit)
               begin
                  retry_go = 1'b1;
               end
               else if (err && ins.fail_bit)
               begin
                  sync_halt = 1'b1;
                  st_next.sync_error_flag = 1'b1;
                  stop_next = 1'b1;
                  gate_next = 1'b0;
                  state_next = disk_seq_pkg::ST_IDLE;
               end
               else if (done || err)
               begin
                  fin = 1'b1;
                  if (ins.last_bit && sc_reg != 8'h00)
                  begin
                     sc_after = sc_reg - 8'h01;
                  end
                  sc_next = sc_after;
                  if (ins.retry_bit && (mism_next || idcrc_next))
                  begin
                     retry_go = 1'b1;
                  end
                  else if (ins.fail_bit && derr_next)
                  begin
                     ecc_halt = 1'b1;
                     st_next.data_check_error_flag = 1'b1;
                     stop_next = 1'b1;
                     gate_next = 1'b0;
                     state_next = disk_seq_pkg::ST_IDLE;
                  end
                  else
                  begin
                     pc_next = (ins.jump_enable_bit && sc_after != 8'h00) ?
                               LOOP_ADDR_I : pc_reg + 5'h01;
                     state_next = disk_seq_pkg::ST_FETCH;
                  end
               end
               if (retry_go)
               begin
                  st_next.id_check_error_flag = st_reg.id_check_error_flag || idcrc_next;
                  mism_next = 1'b0;
                  idcrc_next = 1'b0;
                  derr_next = 1'b0;
                  pc_next = START_ADDR_I;
                  state_next = disk_seq_pkg::ST_FETCH;
               end
            end
         end
      endcase
      if (ABORT_I && state_reg != disk_seq_pkg::ST_IDLE)
      begin
         state_next = disk_seq_pkg::ST_IDLE;
         gate_next = 1'b0;
         stop_next = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state_reg <= disk_seq_pkg::ST_IDLE;
         pc_reg <= '0;
         cnt_reg <= 8'h00;
         sc_reg <= disk_seq_pkg::SECTOR_COUNT_RESET;
         crc_reg <= disk_seq_pkg::CRC_INIT;
         idx_reg <= 2'h0;
         id_reg <= '0;
         st_reg <= '0;
         gate_reg <= 1'b0;
         stop_reg <= 1'b0;
         mism_reg <= 1'b0;
         idcrc_reg <= 1'b0;
         derr_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         cnt_reg <= cnt_next;
         sc_reg <= sc_next;
         crc_reg <= crc_next;
         idx_reg <= idx_next;
         id_reg <= id_next;
         st_reg <= st_next;
         gate_reg <= gate_next;
         stop_reg <= stop_next;
         mism_reg <= mism_next;
         idcrc_reg <= idcrc_next;
         derr_reg <= derr_next;
      end
   end

   assign CMP_TAKE_O = take;
   assign READ_GATE_O = gate_reg;
   assign BUSY_O = (state_reg != disk_seq_pkg::ST_IDLE);
   assign SEQUENCER_STOPPED_O = stop_reg;
   assign STATUS_O = st_reg;
   assign ID_READ_O = id_reg;
   assign SECTOR_COUNT_O = sc_reg;

   sequence s_stop_fetch;
      state_reg == disk_seq_pkg::ST_FETCH && ins.opt == disk_seq_pkg::OPT_STOP && !ABORT_I;
   endsequence
   sequence s_halted;
      state_reg == disk_seq_pkg::ST_IDLE && SEQUENCER_STOPPED_O && !READ_GATE_O;
   endsequence
   property p_stop_ends;
      @(posedge CLK_SYS_I) disable iff (RESET_I) s_stop_fetch |=> s_halted;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("stop code did not halt");
   property p_gate;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         state_reg == disk_seq_pkg::ST_RUN |-> READ_GATE_O == ins.read_gate;
   endproperty
   a_gate: assert property (p_gate) else $error("read gate differs from bit");
   property p_idsearch;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         state_reg == disk_seq_pkg::ST_RUN && ins.opt == disk_seq_pkg::OPT_ID_MARK
         && !MARK_DETECTED_I && !ABORT_I |=> state_reg == disk_seq_pkg::ST_RUN && $stable(pc_reg);
   endproperty
   a_idsearch: assert property (p_idsearch) else $error("id search gave up");
   property p_sync;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         sync_halt && !ABORT_I |=> s_halted and STATUS_O.sync_error_flag;
   endproperty
   a_sync: assert property (p_sync) else $error("sync error did not halt");
   property p_retry;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         retry_go && !ABORT_I |=> state_reg == disk_seq_pkg::ST_FETCH
         && pc_reg == $past(START_ADDR_I) && !mism_reg && !idcrc_reg;
   endproperty
   a_retry: assert property (p_retry) else $error("retry did not restart");
   property p_ecc;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         ecc_halt && !ABORT_I |=> s_halted and STATUS_O.data_check_error_flag;
   endproperty
   a_ecc: assert property (p_ecc) else $error("ecc error did not halt");
   property p_jump;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         fin && !retry_go && !ecc_halt && !ABORT_I |=>
         pc_reg == (($past(ins.jump_enable_bit) && sc_reg != 8'h00) ?
                    $past(LOOP_ADDR_I) : $past(pc_reg) + 5'h01);
   endproperty
   a_jump: assert property (p_jump) else $error("wrong next instruction");
   property p_count;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         state_reg == disk_seq_pkg::ST_FETCH && ins.opt != disk_seq_pkg::OPT_STOP && !ABORT_I
         |=> state_reg == disk_seq_pkg::ST_RUN && cnt_reg == $past(ins.count);
   endproperty
   a_count: assert property (p_count) else $error("count not loaded");
   property p_damlimit;
      @(posedge CLK_SYS_I) disable iff (RESET_I)
         state_reg == disk_seq_pkg::ST_RUN && ins.opt == disk_seq_pkg::OPT_DATA_MARK
         && DISK_VALID_I && cnt_reg == 8'h00 && !(MARK_DETECTED_I && hit) |-> err;
   endproperty
   a_damlimit: assert property (p_damlimit) else $error("data mark search unbounded");
endmodule : disk_read_sector_sequencer

// ===== logic/disk_seq_pkg.sv
// package: constants and types for the read sector sequencer
package disk_seq_pkg;
   localparam int ADDR_W = 5;
   localparam int STORE_DEPTH = 32;
   localparam int FIFO_DEPTH = 32;
   localparam int ID_ADDR_BYTES = 3;
   localparam logic [1:0] ID_FLAG_IDX = 2'h3;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [7:0] SECTOR_COUNT_RESET = 8'h00;

   typedef enum logic [1:0] {OPT_NORMAL, OPT_ID_MARK, OPT_DATA_MARK, OPT_STOP} count_opt_e;
   typedef enum logic [2:0] {SRC_IMM, SRC_ID, SRC_BUF, SRC_NO_TRANSFER_SOURCE, SRC_CHECK} source_e;
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RUN} seq_state_e;

   typedef struct packed {
      logic [7:0] value;
      logic [7:0] count;
      count_opt_e opt;
      source_e src;
      logic read_gate;
      logic compare_bit;
      logic retry_bit;
      logic checksum_select;
      logic fail_bit;
      logic jump_enable_bit;
      logic last_bit;
   } instr_s;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } xfer_s;

   typedef struct packed {
      logic sync_error_flag;
      logic data_check_error_flag;
      logic id_check_error_flag;
      logic overrun_flag;
   } status_s;

   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {b, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_byte
endpackage : disk_seq_pkg

// ===== bench/disk_read_channel_model.sv
// disk read channel model: byte times with address mark qualifier
module disk_read_channel_model (
   input wire logic clk_i,
   output logic [7:0] byte_o,
   output logic valid_o,
   output logic mark_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      byte_o = 8'h00;
      valid_o = 1'b0;
      mark_o = 1'b0;
   end
   // one byte time: valid one cycle, then a gap
   task automatic send(input logic [7:0] b, input logic m);
      @(negedge clk_i);
      byte_o = b;
      valid_o = 1'b1;
      mark_o = m;
      @(negedge clk_i);
      valid_o = 1'b0;
      mark_o = 1'b0;
      byte_o = ~b;
      repeat (3) @(negedge clk_i);
   endtask : send
endmodule : disk_read_channel_model

// ===== bench/disk_read_sector_sequencer_tb_top.sv
// testbench for the read sector sequencer
module disk_read_sector_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, abort, st_wr, sc_wr, read_compare_bit, rdy, xv, rg, busy, stp, ct, dv, dm, xon;
   logic [4:0] st_a, start_a;
   disk_seq_pkg::instr_s st_d;
   disk_seq_pkg::xfer_s xf;
   disk_seq_pkg::status_s sts;
   logic [7:0] sc, db, scnt;
   logic [23:0] tid;
   logic [31:0] idr;
   logic [15:0] crc;
   int mismatches, compares, cyc, stops, takes, s0;
   logic [8:0] exq[$];
   logic [8:0] gotq[$];

   disk_read_sector_sequencer dut (.CLK_SYS_I(clk), .RESET_I(rst), .ABORT_I(abort),
      .STORE_WR_I(st_wr), .STORE_ADDR_I(st_a), .STORE_DATA_I(st_d),
      .START_ADDR_I(start_a), .LOOP_ADDR_I(5'h00), .SECTOR_COUNT_WR_I(sc_wr),
      .SECTOR_COUNT_I(sc), .READ_COMPARE_BIT_I(read_compare_bit), .TARGET_ID_I(tid),
      .DISK_BYTE_I(db), .DISK_VALID_I(dv), .MARK_DETECTED_I(dm), .CMP_DATA_I(8'h00),
      .CMP_TAKE_O(ct), .XFER_O(xf), .XFER_VALID_O(xv), .XFER_READY_I(rdy),
      .READ_GATE_O(rg), .BUSY_O(busy), .SEQUENCER_STOPPED_O(stp), .STATUS_O(sts),
      .ID_READ_O(idr), .SECTOR_COUNT_O(scnt));
   disk_read_channel_model disk (.clk_i(clk), .byte_o(db), .valid_o(dv), .mark_o(dm));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (stp === 1'b1) stops++;
      if (ct === 1'b1) takes++;
      if (xv === 1'b1 && rdy === 1'b1) gotq.push_back(xf);
      if (cyc == 30000)
      begin
         mismatches++;
         results();
      end
   end

   task automatic results();
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         mismatches++;
      end
   endtask : chk

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ disk_seq_pkg::CRC_POLY) : (c << 1);
      return c;
   endfunction : crc_step

   // opt 0 normal 1 id mark 2 data mark 3 stop; src 0 imm 1 id 2 buf 3 none 4 check
   // flags: rg cmp rty sel fail jmp last
   task automatic ld(input logic [4:0] a, input logic [7:0] v, input logic [7:0] c,
      input logic [1:0] o, input logic [2:0] s, input logic [6:0] f);
      @(negedge clk);
      st_wr = 1'b1;
      st_a = a;
      st_d = disk_seq_pkg::instr_s'({v, c, o, s, f});
      @(negedge clk);
      st_wr = 1'b0;
   endtask : ld

   task automatic load(input logic [2:0] ds, input logic [6:0] dc);
      ld(5'h00, 8'ha1, 8'h00, 2'h1, 3'h0, 7'h50);
      ld(5'h01, 8'hfe, 8'h00, 2'h0, 3'h0, 7'h70);
      ld(5'h02, 8'h00, 8'h02, 2'h0, 3'h1, 7'h60);
      ld(5'h03, 8'h00, 8'h00, 2'h0, 3'h1, 7'h40);
      ld(5'h04, 8'h00, 8'h01, 2'h0, 3'h4, 7'h40);
      ld(5'h05, 8'h00, 8'h03, 2'h0, 3'h0, 7'h10);
      ld(5'h06, 8'ha1, 8'h1f, 2'h2, 3'h0, 7'h4c);
      ld(5'h07, 8'hf8, 8'h00, 2'h0, 3'h0, 7'h6c);
      for (int i = 8; i < 12; i++) ld(5'(i), 8'h00, 8'h03, 2'h0, ds, 7'h48 | dc | 7'(i == 11));
      ld(5'h0c, 8'h00, 8'h1d, 2'h0, 3'h4, 7'h48);
      ld(5'h0d, 8'h00, 8'h02, 2'h0, 3'h0, 7'h0e);
      ld(5'h0e, 8'h00, 8'h00, 2'h3, 3'h0, 7'h00);
   endtask : load

   task automatic snd(input logic [7:0] b, input logic m);
      disk.send(b, m);
      crc = crc_step(crc, b);
   endtask : snd

   task automatic start(input logic [7:0] n);
      exq.delete();
      gotq.delete();
      @(negedge clk);
      sc_wr = 1'b1;
      sc = n;
      @(negedge clk);
      sc_wr = 1'b0;
      chk("busy", 32'(busy), 32'h1);
      chk("sector count", 32'(scnt), 32'(n));
      chk("status", 32'(sts), 32'h0);
      s0 = stops;
   endtask : start

   task automatic idle();
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
      // stop pulse is counted at the edge after busy falls
      @(negedge clk);
      chk("busy", 32'(busy), 32'h0);
      chk("stops", 32'(stops - s0), 32'h1);
   endtask : idle

   task automatic hdr(input logic [23:0] id, input logic [7:0] fl, input logic [7:0] mk,
      input logic [15:0] bad);
      logic [15:0] x;
      disk.send(8'h55, 1'b0);
      crc = disk_seq_pkg::CRC_INIT;
      snd(8'ha1, 1'b1);
      snd(mk, 1'b0);
      for (int i = 0; i < 3; i++) snd(id[8*i+:8], 1'b0);
      snd(fl, 1'b0);
      x = crc ^ bad;
      snd(x[15:8], 1'b0);
      snd(x[7:0], 1'b0);
      repeat (4) snd(8'h00, 1'b0);
   endtask : hdr

   task automatic dat(input logic [7:0] base, input logic [15:0] bad);
      logic [15:0] x;
      disk.send(8'h55, 1'b0);
      crc = disk_seq_pkg::CRC_INIT;
      snd(8'ha1, 1'b1);
      snd(8'hf8, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         snd(base + 8'(i), 1'b0);
         if (xon) exq.push_back({base + 8'(i), i == 15});
      end
      x = crc ^ bad;
      snd(x[15:8], 1'b0);
      snd(x[7:0], 1'b0);
      repeat (28) snd(8'h00, 1'b0);
      chk("read gate", 32'(rg), 32'h0);
      repeat (3) snd(8'h00, 1'b0);
   endtask : dat

   task automatic t_stop_code();
      start_a = 5'h0e;
      start(8'h01);
      idle();
      start_a = 5'h00;
   endtask : t_stop_code

   task automatic t_search_abort();
      start(8'h01);
      disk.send(8'ha1, 1'b0);
      repeat (300) @(negedge clk);
      chk("busy", 32'(busy), 32'h1);
      abort = 1'b1;
      @(negedge clk);
      abort = 1'b0;
      idle();
      chk("status", 32'(sts), 32'h0);
   endtask : t_search_abort

   task automatic t_read_two();
      xon = 1'b1;
      rdy = 1'b0;
      start(8'h02);
      hdr(tid, 8'h5a, 8'hfe, 16'h0000);
      chk("id read", idr, {8'h5a, tid});
      chk("read gate", 32'(rg), 32'h1);
      dat(8'h10, 16'h0000);
      rdy = 1'b1;
      hdr(tid, 8'h5b, 8'hfe, 16'h0000);
      dat(8'h20, 16'h0000);
      idle();
      chk("sector count", 32'(scnt), 32'h0);
      chk("status", 32'(sts), 32'h0);
      chk("xfer count", 32'(gotq.size()), 32'd32);
      for (int i = 0; i < 32 && i < gotq.size(); i++) chk("xfer", 32'(gotq[i]), 32'(exq[i]));
   endtask : t_read_two

   task automatic t_retries();
      start(8'h01);
      hdr(tid, 8'h00, 8'hfd, 16'h0000);
      hdr(tid ^ 24'h000001, 8'h00, 8'hfe, 16'h0000);
      chk("id flag", 32'(sts.id_check_error_flag), 32'h0);
      hdr(tid, 8'h00, 8'hfe, 16'h0001);
      chk("id flag", 32'(sts.id_check_error_flag), 32'h1);
      hdr(tid, 8'h77, 8'hfe, 16'h0000);
      dat(8'h30, 16'h0000);
      idle();
      chk("id read", idr, {8'h77, tid});
   endtask : t_retries

   task automatic t_sync(input logic [7:0] mk);
      start(8'h01);
      hdr(tid, 8'h00, 8'hfe, 16'h0000);
      if (mk == 8'h00)
      begin
         repeat (31) disk.send(8'ha1, 1'b0);
         chk("busy", 32'(busy), 32'h1);
         disk.send(8'ha1, 1'b0);
      end
      else
      begin
         disk.send(8'ha1, 1'b1);
         disk.send(mk, 1'b0);
      end
      idle();
      chk("sync flag", 32'(sts.sync_error_flag), 32'h1);
   endtask : t_sync

   task automatic t_data_err(input logic [2:0] ds, input logic [15:0] bad);
      xon = 1'b0;
      read_compare_bit = (ds == 3'h2);
      load(ds, read_compare_bit ? 7'h20 : 7'h00);
      takes = 0;
      start(8'h01);
      hdr(tid, 8'h00, 8'hfe, 16'h0000);
      dat(8'h40, bad);
      idle();
      chk("data flag", 32'(sts.data_check_error_flag), 32'h1);
      chk("xfer count", 32'(gotq.size()), 32'h0);
      chk("takes", 32'(takes), read_compare_bit ? 32'd16 : 32'd0);
      read_compare_bit = 1'b0;
   endtask : t_data_err

   initial
   begin
      {rst, abort, st_wr, sc_wr, read_compare_bit, rdy, xon} = 7'h40;
      {st_a, start_a, sc, crc} = 34'h0;
      st_d = '0;
      tid = 24'h3c2b1a;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      load(3'h2, 7'h00);
      t_stop_code();
      t_search_abort();
      t_read_two();
      t_retries();
      t_sync(8'h00);
      t_sync(8'hf7);
      t_data_err(3'h2, 16'h0000);
      t_data_err(3'h3, 16'h0100);
      results();
   end
endmodule : disk_read_sector_sequencer_tb_top
